/* File: core_model.sv */
`timescale 1ns/1ps
module core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Request in, vector fetch out
    input wire logic normal_irq,
    output logic normal_vector_taken
);
    logic seen;
    // One vector fetch per new request
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            seen <= 1'b0;
            normal_vector_taken <= 1'b0;
        end else begin
            seen <= normal_irq;
            normal_vector_taken <= normal_irq && !seen;
        end
    end
endmodule

/* File: fast_irq_nest_ctrl.sv */
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - Fast vector reads zeros 31:23, table base 22:7, source index 6:2, zeros 1:0.
// - Fast vector value addresses the stored handler pointer of the active fast source.
// - Fast vector read with nesting on sets fast status bit at source priority.
// - With nesting on, any set status bit blocks sources of that priority and lower.
// - Every nest level status write clears only the lowest-numbered set bit, value ignored.
// - Four pins and two array lines, each high, low, rising or falling.
// - Trigger code 11 falling, 10 rising, 01 low level, 00 high level.
// - Trigger fields: ext0 1:0, ext1 3:2, array0 5:4, ext2 7:6, ext3 9:8, array1 11:10.
// - Writing one to a source's clear bit drops its latched edge.
// - Fast status holds bits 7:0, upper bits reserved, resets to zero.
// - Nesting control bit 1 enables fast nesting, bit 0 normal nesting.
// - Without nesting a pending fast interrupt wins over a pending normal one.
// - Each source carries a 3-bit priority selecting the status bit set.
module fast_irq_nest_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Avalon-MM slave
    input wire logic [31:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Source inputs
    input wire logic [3:0] ext_pin,
    input wire logic [1:0] logic_array_irq,
    input wire logic [17:0] source_priority,
    input wire logic normal_vector_taken,
    // Requests to the core
    output logic fast_irq,
    output logic normal_irq,
    output logic [4:0] normal_source_index,
    // Event interrupt
    output logic irq
);

    localparam int N = fiq_nest_pkg::NUM_SOURCES;

    // Pin synchronisers
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    // Bus state
    logic [31:0] next_readdata;
    logic next_waitrequest;
    logic accept_read;
    logic accept_write;
    logic [31:0] read_mux;
    logic vec_found;
    logic [2:0] vec_prio;
    logic next_vec_found;
    logic [2:0] next_vec_prio;
    // Configuration
    logic [1:0] nesting_control;
    logic [11:0] ext_trigger_select;
    logic [15:0] vector_table_base;
    logic [5:0] fast_source_enable;
    logic [5:0] normal_source_enable;
    logic [5:0] event_mask;
    logic [1:0] next_nesting_control;
    logic [11:0] next_ext_trigger_select;
    logic [15:0] next_vector_table_base;
    logic [5:0] next_fast_source_enable;
    logic [5:0] next_normal_source_enable;
    logic [5:0] next_event_mask;
    // Nest level status
    logic [7:0] fast_nest_level_status;
    logic [7:0] normal_nest_level_status;
    logic [7:0] next_fast_nest_level_status;
    logic [7:0] next_normal_nest_level_status;
    // Sources and arbitration
    logic [5:0] raw_source;
    logic [5:0] edge_clear;
    logic [5:0] request;
    logic [5:0] fast_eligible;
    logic [5:0] normal_eligible;
    logic fast_nest_en;
    logic normal_nest_en;
    logic fast_found;
    logic [2:0] fast_sel;
    logic [2:0] fast_prio;
    logic normal_found;
    logic [2:0] normal_sel;
    logic [2:0] normal_prio;
    // Events and core outputs
    logic [5:0] request_q;
    logic [5:0] event_status;
    logic [5:0] next_request_q;
    logic [5:0] next_event_status;
    logic next_irq;
    logic next_fast_irq;
    logic next_normal_irq;
    logic [4:0] next_normal_source_index;

    // Mask of priority levels 0 to p
    function automatic logic [7:0] at_or_above(input logic [2:0] p);
        logic [8:0] m;
        m = (9'h002 << p) - 9'h001;
        return m[7:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; only the second stage feeds logic
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
        end else begin
            pin_meta <= ext_pin;
            pin_sync <= pin_meta;
        end
    end

    assign raw_source = {logic_array_irq[1], pin_sync[3], pin_sync[2],
                         logic_array_irq[0], pin_sync[1], pin_sync[0]};
    assign fast_nest_en = nesting_control[fiq_nest_pkg::FAST_NEST_BIT];
    assign normal_nest_en = nesting_control[fiq_nest_pkg::NORMAL_NEST_BIT];
    assign accept_read = read && !waitrequest;
    assign accept_write = write && !waitrequest;

    ////////////////////////////////////////////////////////////////////////////
    // Per-source trigger, clear decode and nesting block
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gen_src
            logic [2:0] prio;
            assign prio = source_priority[g*3 +: 3];
            assign edge_clear[g] = accept_write && address == fiq_nest_pkg::ADDR_EDGE_LATCH_CLEAR
                                   && writedata[fiq_nest_pkg::CLEAR_BIT[g]];
            src_trigger u_trig (
                .clk(clk),
                .rst_b(rst_b),
                .sample(raw_source[g]),
                .trigger(ext_trigger_select[g*2 +: 2]),
                .edge_clear(edge_clear[g]),
                .request(request[g])
            );
            // A status bit at this level or above blocks it
            assign fast_eligible[g] = request[g] && fast_source_enable[g]
                && !(fast_nest_en && |(fast_nest_level_status & at_or_above(prio)));
            assign normal_eligible[g] = request[g] && normal_source_enable[g]
                && !(normal_nest_en && |(normal_nest_level_status & at_or_above(prio)));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration: best priority when nesting, lowest source otherwise
    always_comb begin
        fast_found = 1'b0;
        fast_sel = 3'h0;
        fast_prio = 3'h0;
        normal_found = 1'b0;
        normal_sel = 3'h0;
        normal_prio = 3'h0;
        for (int i = 0; i < N; i++) begin
            if (fast_eligible[i] && (!fast_found
                || (fast_nest_en && source_priority[i*3 +: 3] < fast_prio))) begin
                fast_found = 1'b1;
                fast_sel = 3'(i);
                fast_prio = source_priority[i*3 +: 3];
            end
            if (normal_eligible[i] && (!normal_found
                || (normal_nest_en && source_priority[i*3 +: 3] < normal_prio))) begin
                normal_found = 1'b1;
                normal_sel = 3'(i);
                normal_prio = source_priority[i*3 +: 3];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data mux
    always_comb begin
        read_mux = fiq_nest_pkg::RESET_WORD;
        case (address)
            fiq_nest_pkg::ADDR_NESTING_CONTROL: begin
                read_mux = {30'h00000000, nesting_control};
            end
            fiq_nest_pkg::ADDR_EXT_TRIGGER_SELECT: begin
                read_mux = {20'h00000, ext_trigger_select};
            end
            fiq_nest_pkg::ADDR_NORMAL_NEST_LEVEL_STATUS: begin
                read_mux = {24'h000000, normal_nest_level_status};
            end
            fiq_nest_pkg::ADDR_VECTOR_TABLE_BASE: begin
                read_mux = {16'h0000, vector_table_base};
            end
            fiq_nest_pkg::ADDR_EVENT_STATUS: begin
                read_mux = {26'h0000000, event_status};
            end
            fiq_nest_pkg::ADDR_EVENT_MASK: begin
                read_mux = {26'h0000000, event_mask};
            end
            fiq_nest_pkg::ADDR_FAST_SOURCE_ENABLE: begin
                read_mux = {26'h0000000, fast_source_enable};
            end
            fiq_nest_pkg::ADDR_NORMAL_SOURCE_ENABLE: begin
                read_mux = {26'h0000000, normal_source_enable};
            end
            fiq_nest_pkg::ADDR_FAST_VECTOR_POINTER: begin
                // Address of the handler pointer slot
                read_mux = {9'h000, vector_table_base,
                            fast_found ? 5'(fiq_nest_pkg::SOURCE_INDEX[fast_sel]) : 5'h00,
                            2'h0};
            end
            fiq_nest_pkg::ADDR_FAST_NEST_LEVEL_STATUS: begin
                read_mux = {24'h000000, fast_nest_level_status};
            end
            default: begin
                read_mux = fiq_nest_pkg::RESET_WORD;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // One wait cycle, then data and acceptance together
    always_comb begin
        next_waitrequest = !((read || write) && waitrequest);
        next_readdata = readdata;
        next_vec_found = vec_found;
        next_vec_prio = vec_prio;
        if (read && waitrequest) begin
            next_readdata = read_mux;
            // Priority frozen with the data, so the set bit matches the read
            next_vec_found = fast_found;
            next_vec_prio = fast_prio;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            waitrequest <= 1'b1;
            readdata <= fiq_nest_pkg::RESET_WORD;
            vec_found <= 1'b0;
            vec_prio <= 3'h0;
        end else begin
            waitrequest <= next_waitrequest;
            readdata <= next_readdata;
            vec_found <= next_vec_found;
            vec_prio <= next_vec_prio;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_comb begin
        next_nesting_control = nesting_control;
        next_ext_trigger_select = ext_trigger_select;
        next_vector_table_base = vector_table_base;
        next_fast_source_enable = fast_source_enable;
        next_normal_source_enable = normal_source_enable;
        next_event_mask = event_mask;
        if (accept_write) begin
            case (address)
                fiq_nest_pkg::ADDR_NESTING_CONTROL: begin
                    next_nesting_control = writedata[1:0];
                end
                fiq_nest_pkg::ADDR_EXT_TRIGGER_SELECT: begin
                    next_ext_trigger_select = writedata[11:0];
                end
                fiq_nest_pkg::ADDR_VECTOR_TABLE_BASE: begin
                    next_vector_table_base = writedata[15:0];
                end
                fiq_nest_pkg::ADDR_FAST_SOURCE_ENABLE: begin
                    next_fast_source_enable = writedata[5:0];
                end
                fiq_nest_pkg::ADDR_NORMAL_SOURCE_ENABLE: begin
                    next_normal_source_enable = writedata[5:0];
                end
                fiq_nest_pkg::ADDR_EVENT_MASK: begin
                    next_event_mask = writedata[5:0];
                end
                default: begin
                    next_event_mask = event_mask;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nesting_control <= fiq_nest_pkg::RESET_NESTING_CONTROL;
            ext_trigger_select <= fiq_nest_pkg::RESET_TRIGGER_SELECT;
            vector_table_base <= fiq_nest_pkg::RESET_VECTOR_BASE;
            fast_source_enable <= fiq_nest_pkg::RESET_SOURCE_BITS;
            normal_source_enable <= fiq_nest_pkg::RESET_SOURCE_BITS;
            event_mask <= fiq_nest_pkg::RESET_SOURCE_BITS;
        end else begin
            nesting_control <= next_nesting_control;
            ext_trigger_select <= next_ext_trigger_select;
            vector_table_base <= next_vector_table_base;
            fast_source_enable <= next_fast_source_enable;
            normal_source_enable <= next_normal_source_enable;
            event_mask <= next_event_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Nest level status: clear lowest set bit first, then set wins
    always_comb begin
        next_fast_nest_level_status = fast_nest_level_status;
        next_normal_nest_level_status = normal_nest_level_status;
        if (accept_write && address == fiq_nest_pkg::ADDR_FAST_NEST_LEVEL_STATUS) begin
            // Written value ignored; a single bit drops per write
            next_fast_nest_level_status = fast_nest_level_status
                                          & (fast_nest_level_status - 8'h01);
        end
        if (accept_write && address == fiq_nest_pkg::ADDR_NORMAL_NEST_LEVEL_STATUS) begin
            next_normal_nest_level_status = normal_nest_level_status
                                            & (normal_nest_level_status - 8'h01);
        end
        if (accept_read && address == fiq_nest_pkg::ADDR_FAST_VECTOR_POINTER
            && fast_nest_en && vec_found) begin
            next_fast_nest_level_status = next_fast_nest_level_status
                                          | (8'h01 << vec_prio);
        end
        if (normal_vector_taken && normal_nest_en && normal_found) begin
            next_normal_nest_level_status = next_normal_nest_level_status
                                            | (8'h01 << normal_prio);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fast_nest_level_status <= fiq_nest_pkg::RESET_NEST_LEVEL;
            normal_nest_level_status <= fiq_nest_pkg::RESET_NEST_LEVEL;
        end else begin
            fast_nest_level_status <= next_fast_nest_level_status;
            normal_nest_level_status <= next_normal_nest_level_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event flags, interrupt line and core requests
    always_comb begin
        next_request_q = request;
        next_event_status = event_status;
        if (accept_write && address == fiq_nest_pkg::ADDR_EVENT_STATUS) begin
            next_event_status = event_status & ~writedata[5:0];
        end
        // Rising request is the event; it beats a same-cycle clear
        next_event_status = next_event_status | (request & ~request_q);
        next_irq = |(next_event_status & next_event_mask);
        next_fast_irq = fast_found;
        // Without nesting, fast masks normal
        next_normal_irq = normal_found && !(fast_found && !fast_nest_en && !normal_nest_en);
        next_normal_source_index = normal_found ? 5'(fiq_nest_pkg::SOURCE_INDEX[normal_sel])
                                                : 5'h00;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            request_q <= fiq_nest_pkg::RESET_SOURCE_BITS;
            event_status <= fiq_nest_pkg::RESET_SOURCE_BITS;
            irq <= 1'b0;
            fast_irq <= 1'b0;
            normal_irq <= 1'b0;
            normal_source_index <= 5'h00;
        end else begin
            request_q <= next_request_q;
            event_status <= next_event_status;
            irq <= next_irq;
            fast_irq <= next_fast_irq;
            normal_irq <= next_normal_irq;
            normal_source_index <= next_normal_source_index;
        end
    end

endmodule

/* File: fiq_nest_pkg.sv */
package fiq_nest_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [31:0] ADDR_NESTING_CONTROL = 32'hFFFF0030;
    localparam logic [31:0] ADDR_EXT_TRIGGER_SELECT = 32'hFFFF0034;
    localparam logic [31:0] ADDR_EDGE_LATCH_CLEAR = 32'hFFFF0038;
    localparam logic [31:0] ADDR_NORMAL_NEST_LEVEL_STATUS = 32'hFFFF003C;
    localparam logic [31:0] ADDR_VECTOR_TABLE_BASE = 32'hFFFF0040;
    localparam logic [31:0] ADDR_EVENT_STATUS = 32'hFFFF0044;
    localparam logic [31:0] ADDR_EVENT_MASK = 32'hFFFF0048;
    localparam logic [31:0] ADDR_FAST_SOURCE_ENABLE = 32'hFFFF0050;
    localparam logic [31:0] ADDR_NORMAL_SOURCE_ENABLE = 32'hFFFF0054;
    localparam logic [31:0] ADDR_FAST_VECTOR_POINTER = 32'hFFFF011C;
    localparam logic [31:0] ADDR_FAST_NEST_LEVEL_STATUS = 32'hFFFF013C;

    ////////////////////////////////////////////////////////////////////////////
    // Widths and field positions
    localparam int NUM_SOURCES = 6;
    localparam int FAST_NEST_BIT = 1;
    localparam int NORMAL_NEST_BIT = 0;

    // Edge clear bit per source: ext0, ext1, array0, ext2, ext3, array1
    localparam int CLEAR_BIT [NUM_SOURCES] = '{13, 16, 17, 18, 19, 20};
    // Vector index (0 to 27) reported for each source, same order
    localparam int SOURCE_INDEX [NUM_SOURCES] = '{13, 16, 17, 18, 19, 20};

    ////////////////////////////////////////////////////////////////////////////
    // Trigger encodings
    localparam logic [1:0] TRIG_HIGH_LEVEL = 2'h0;
    localparam logic [1:0] TRIG_LOW_LEVEL = 2'h1;
    localparam logic [1:0] TRIG_RISING_EDGE = 2'h2;
    localparam logic [1:0] TRIG_FALLING_EDGE = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [31:0] RESET_WORD = 32'h00000000;
    localparam logic [1:0] RESET_NESTING_CONTROL = 2'h0;
    localparam logic [11:0] RESET_TRIGGER_SELECT = 12'h000;
    localparam logic [7:0] RESET_NEST_LEVEL = 8'h00;
    localparam logic [15:0] RESET_VECTOR_BASE = 16'h0000;
    localparam logic [5:0] RESET_SOURCE_BITS = 6'h00;

endpackage

/* File: irq_nest_checker_sva.sv */
`timescale 1ns/1ps
module irq_nest_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register bus
    input wire logic [31:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Requests
    input wire logic fast_irq,
    input wire logic normal_irq,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////////
    // One wait cycle per access, low for one cycle
    reset_quiet_a: assert property ($rose(rst_b) |-> waitrequest && !fast_irq && !irq)
        else $error("outputs not quiet after reset");
    access_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("access not answered after one wait cycle");
    wait_pulse_a: assert property ($fell(waitrequest) |=> waitrequest)
        else $error("waitrequest low longer than one cycle");
    idle_wait_a: assert property (!read && !write && waitrequest |=> waitrequest)
        else $error("waitrequest dropped without a request");
    ////////////////////////////////////////////////////////////////////////////
    // Read layouts at the accepting edge
    vector_zeros_a: assert property (read && !waitrequest &&
        address == fiq_nest_pkg::ADDR_FAST_VECTOR_POINTER |->
        readdata[31:23] == 9'h000 && readdata[1:0] == 2'h0)
        else $error("fast vector fixed bits not zero");
    vector_index_a: assert property (read && !waitrequest &&
        address == fiq_nest_pkg::ADDR_FAST_VECTOR_POINTER |-> readdata[6:2] <= 5'h1B)
        else $error("fast vector index out of range");
    status_upper_a: assert property (read && !waitrequest &&
        address == fiq_nest_pkg::ADDR_FAST_NEST_LEVEL_STATUS |-> readdata[31:8] == 24'h000000)
        else $error("fast nest status upper bits set");
    trigger_upper_a: assert property (read && !waitrequest &&
        address == fiq_nest_pkg::ADDR_EXT_TRIGGER_SELECT |-> readdata[31:12] == 20'h00000)
        else $error("trigger select reserved bits set");
    // Main scenarios reached
    fast_seen_c: cover property ($rose(fast_irq));
    normal_seen_c: cover property ($rose(normal_irq));
    event_seen_c: cover property ($rose(irq));
endmodule
bind fast_irq_nest_ctrl irq_nest_checker chk_i (.clk(clk), .rst_b(rst_b), .address(address),
    .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .fast_irq(fast_irq), .normal_irq(normal_irq), .irq(irq));

/* File: src_trigger.sv */
`timescale 1ns/1ps
module src_trigger (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Source sample, already in the clock domain
    input wire logic sample,
    input wire logic [1:0] trigger,
    input wire logic edge_clear,
    // Request toward arbitration
    output logic request
);

    logic prev;
    logic primed;
    logic pending;
    logic next_prev;
    logic next_primed;
    logic next_pending;
    logic edge_hit;
    logic level_hit;
    logic is_edge;

    ////////////////////////////////////////////////////////////////////////////
    // Decode the trigger mode and compare successive samples
    always_comb begin
        is_edge = trigger[1];
        level_hit = (trigger == fiq_nest_pkg::TRIG_HIGH_LEVEL) ? sample : !sample;
        edge_hit = 1'b0;
        // No edge on the first sample after reset
        if (primed && trigger == fiq_nest_pkg::TRIG_RISING_EDGE) begin
            edge_hit = sample && !prev;
        end else if (primed && trigger == fiq_nest_pkg::TRIG_FALLING_EDGE) begin
            edge_hit = !sample && prev;
        end
        next_prev = sample;
        next_primed = 1'b1;
        // Level modes never latch
        if (!is_edge) begin
            next_pending = 1'b0;
        end else begin
            // A new edge beats a same-cycle clear
            next_pending = (pending && !edge_clear) || edge_hit;
        end
        request = is_edge ? pending : level_hit;
    end

    // State registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev <= 1'b0;
            primed <= 1'b0;
            pending <= 1'b0;
        end else begin
            prev <= next_prev;
            primed <= next_primed;
            pending <= next_pending;
        end
    end

endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [31:0] address = 32'h0, writedata = 32'h0, readdata, q;
    logic read = 1'b0, write = 1'b0, waitrequest, taken, fast_irq, normal_irq, irq;
    logic [3:0] ext_pin = 4'h0;
    logic [1:0] logic_array_irq = 2'h0;
    logic [17:0] source_priority = 18'h000C0;
    logic [4:0] nsi;
    int miscompares = 0, n_checks = 0, cyc = 0;
    logic [31:0] rst_addr [5] = '{fiq_nest_pkg::ADDR_EXT_TRIGGER_SELECT,
        fiq_nest_pkg::ADDR_EDGE_LATCH_CLEAR, fiq_nest_pkg::ADDR_FAST_VECTOR_POINTER,
        fiq_nest_pkg::ADDR_FAST_NEST_LEVEL_STATUS, 32'hFFFF0100};
    fast_irq_nest_ctrl dut (.clk(clk), .rst_b(rst_b), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .ext_pin(ext_pin), .logic_array_irq(logic_array_irq), .source_priority(source_priority),
        .normal_vector_taken(taken), .fast_irq(fast_irq), .normal_irq(normal_irq),
        .normal_source_index(nsi), .irq(irq));
    core_model core (.clk(clk), .rst_b(rst_b), .normal_irq(normal_irq), .normal_vector_taken(taken));
    always #10 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    // Bus access, held until waitrequest is seen low
    task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        read <= !w;
        write <= w;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) miscompares++;
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic rdc(input string s, input logic [31:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(s, e, q);
    endtask
    task automatic cy(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard, well above the test length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            wrap_up;
        end
    end
    initial begin
        cy(8);
        rst_b <= 1'b1;
        cy(1);
        foreach (rst_addr[i]) rdc("reset value", rst_addr[i], 32'h0);
        acc(1'b1, fiq_nest_pkg::ADDR_EXT_TRIGGER_SELECT, 32'hFFFFFFFF);
        rdc("trigger fields", fiq_nest_pkg::ADDR_EXT_TRIGGER_SELECT, 32'h00000FFF);
        $display("test registers done");
        // Each trigger code on pin 0: idle, active, then clear attempt
        acc(1'b1, fiq_nest_pkg::ADDR_FAST_SOURCE_ENABLE, 32'h1);
        for (int m = 0; m < 4; m++) begin
            ext_pin[0] <= m[0];
            acc(1'b1, fiq_nest_pkg::ADDR_EXT_TRIGGER_SELECT, m);
            cy(4);
            acc(1'b1, fiq_nest_pkg::ADDR_EDGE_LATCH_CLEAR, 32'h2000);
            cy(2);
            chk("idle request", 32'h0, {31'h0, fast_irq});
            ext_pin[0] <= !m[0];
            cy(6);
            chk("active request", 32'h1, {31'h0, fast_irq});
            acc(1'b1, fiq_nest_pkg::ADDR_EDGE_LATCH_CLEAR, 32'h2000);
            cy(3);
            chk("after clear", {31'h0, m < 2}, {31'h0, fast_irq});
            ext_pin[0] <= m[0];
            cy(6);
        end
        ext_pin[0] <= 1'b0;
        acc(1'b1, fiq_nest_pkg::ADDR_EXT_TRIGGER_SELECT, 32'h0);
        $display("test triggers done");
        // Event interrupt: masked, unmasked, cleared
        chk("masked irq", 32'h0, {31'h0, irq});
        acc(1'b1, fiq_nest_pkg::ADDR_EVENT_MASK, 32'h1);
        cy(2);
        chk("unmasked irq", 32'h1, {31'h0, irq});
        acc(1'b1, fiq_nest_pkg::ADDR_EVENT_STATUS, 32'h3F);
        cy(2);
        chk("cleared irq", 32'h0, {31'h0, irq});
        $display("test events done");
        // Fast nesting: array line 0 at priority 3, then line 1 at priority 0
        acc(1'b1, fiq_nest_pkg::ADDR_VECTOR_TABLE_BASE, 32'h1234);
        acc(1'b1, fiq_nest_pkg::ADDR_NESTING_CONTROL, 32'h2);
        acc(1'b1, fiq_nest_pkg::ADDR_FAST_SOURCE_ENABLE, 32'h24);
        logic_array_irq <= 2'h1;
        cy(4);
        rdc("vector", fiq_nest_pkg::ADDR_FAST_VECTOR_POINTER, 32'h91A44);
        rdc("fast status", fiq_nest_pkg::ADDR_FAST_NEST_LEVEL_STATUS, 32'h8);
        cy(2);
        chk("blocked", 32'h0, {31'h0, fast_irq});
        logic_array_irq <= 2'h3;
        cy(4);
        chk("higher passes", 32'h1, {31'h0, fast_irq});
        rdc("vector", fiq_nest_pkg::ADDR_FAST_VECTOR_POINTER, 32'h91A50);
        rdc("fast status", fiq_nest_pkg::ADDR_FAST_NEST_LEVEL_STATUS, 32'h9);
        acc(1'b1, fiq_nest_pkg::ADDR_FAST_NEST_LEVEL_STATUS, 32'hFFFFFFFF);
        rdc("one clear", fiq_nest_pkg::ADDR_FAST_NEST_LEVEL_STATUS, 32'h8);
        acc(1'b1, fiq_nest_pkg::ADDR_FAST_NEST_LEVEL_STATUS, 32'hFFFFFFFF);
        rdc("two clears", fiq_nest_pkg::ADDR_FAST_NEST_LEVEL_STATUS, 32'h0);
        $display("test fast nesting done");
        // Normal nesting through the core's vector fetch
        logic_array_irq <= 2'h0;
        acc(1'b1, fiq_nest_pkg::ADDR_FAST_SOURCE_ENABLE, 32'h0);
        acc(1'b1, fiq_nest_pkg::ADDR_NESTING_CONTROL, 32'h1);
        acc(1'b1, fiq_nest_pkg::ADDR_NORMAL_SOURCE_ENABLE, 32'h4);
        logic_array_irq <= 2'h1;
        cy(6);
        rdc("normal status", fiq_nest_pkg::ADDR_NORMAL_NEST_LEVEL_STATUS, 32'h8);
        chk("normal blocked", 32'h0, {31'h0, normal_irq});
        acc(1'b1, fiq_nest_pkg::ADDR_NESTING_CONTROL, 32'h0);
        cy(2);
        chk("normal index", 32'h31, {26'h0, normal_irq, nsi});
        acc(1'b1, fiq_nest_pkg::ADDR_FAST_SOURCE_ENABLE, 32'h4);
        cy(2);
        chk("fast first", 32'h2, {30'h0, fast_irq, normal_irq});
        $display("test normal nesting done");
        wrap_up;
    end
endmodule
